// file: design/status_control_register_port.sv
// bit-addressable status and control register behind two internal channels
`timescale 1ns/1ps
`default_nettype none
module status_control_register_port
   import scr_pkg::*;
#(
   parameter bit                  SECOND_PRESENT = 1'b1,
   parameter logic [NUM_BITS-1:0] READ_ONLY_MASK = DEF_READ_ONLY,
   parameter logic [NUM_BITS-1:0] DEADSTART_MASK = DEF_DEADSTART,
   parameter logic [NUM_BITS-1:0] IMPL_MASK      = DEF_IMPL,
   parameter logic [NUM_BITS-1:0] SECOND_MASK    = DEF_SECOND
) (
   input  wire logic                core_clk,
   input  wire logic                reset_n,
   input  wire logic                deadstart,
   input  wire logic [NUM_BITS-1:0] status_valid,
   input  wire logic [NUM_BITS-1:0] status_value,
   input  wire logic                pri_out_valid,
   input  wire logic [WORD_W-1:0]   pri_out_data,
   input  wire logic                pri_in_take,
   output var  logic [WORD_W-1:0]   pri_in_data,
   output var  logic                pri_full,
   input  wire logic                sec_out_valid,
   input  wire logic [WORD_W-1:0]   sec_out_data,
   input  wire logic                sec_in_take,
   output var  logic [WORD_W-1:0]   sec_in_data,
   output var  logic                sec_full,
   output var  logic                chan_active,
   output var  logic [NUM_BITS-1:0] control_bits,
   output var  logic                central_busy_clear,
   output var  logic                memory_data_returned_signal
);
   //----------------------------------------------------------------
   // access helpers
   //----------------------------------------------------------------
   logic [NUM_BITS-1:0] regs;
   logic [NUM_BITS-1:0] next_regs;
   logic                pri_accept;
   logic                sec_accept;
   logic [WORD_W-1:0]   pri_answer;
   logic [WORD_W-1:0]   sec_answer;

   // bits held by a set error flag
   function automatic logic [NUM_BITS-1:0] locked(input logic [NUM_BITS-1:0] r);
      locked = r[LOCK_FLAG_BIT] ? LOCK_GROUP : '0;
   endfunction

   // bits a single-bit function may change
   function automatic logic [NUM_BITS-1:0] writable(input logic [NUM_BITS-1:0] r,
                                                    input logic [NUM_BITS-1:0] vis);
      writable = vis & IMPL_MASK & ~READ_ONLY_MASK & ~locked(r);
   endfunction

   // status word produced for a descriptor
   function automatic logic [WORD_W-1:0] answer(input logic [NUM_BITS-1:0] r,
                                                input logic [WORD_W-1:0]   d,
                                                input logic [NUM_BITS-1:0] vis);
      logic [7:0]          a;
      logic [NUM_BITS-1:0] m;
      logic [NUM_BITS-1:0] w;
      int                  idx;
      a   = d[ADDR_MSB:ADDR_LSB];
      m   = r & vis & IMPL_MASK;
      w   = writable(r, vis);
      idx = int'(a) * WORD_W;
      answer = STATUS_RESET;
      unique case (func_t'(d[FUNC_MSB:FUNC_LSB]))
         FN_READ: begin
            if (int'(a) < NUM_WORDS) answer = m[idx +: WORD_W];
         end
         FN_TEST, FN_TEST_CLEAR, FN_TEST_SET: begin
            // read-only and locked bits test as zero
            if (int'(a) < NUM_BITS) answer[0] = m[a] & w[a];
         end
         FN_TEST_ERROR: answer[0] = |(r[SUMMARY_LAST:0] & IMPL_MASK[SUMMARY_LAST:0]);
         FN_CLEAR, FN_SET, FN_CLEAR_ALL: answer = STATUS_RESET;
      endcase
   endfunction

   // register contents after a descriptor; no word write exists
   function automatic logic [NUM_BITS-1:0] apply(input logic [NUM_BITS-1:0] r,
                                                 input logic [WORD_W-1:0]   d,
                                                 input logic [NUM_BITS-1:0] vis);
      logic [7:0]          a;
      logic [NUM_BITS-1:0] w;
      a = d[ADDR_MSB:ADDR_LSB];
      w = writable(r, vis);
      apply = r;
      unique case (func_t'(d[FUNC_MSB:FUNC_LSB]))
         FN_CLEAR, FN_TEST_CLEAR: begin
            if (int'(a) < NUM_BITS && w[a]) apply[a] = 1'b0;
         end
         FN_SET, FN_TEST_SET: begin
            if (int'(a) < NUM_BITS && w[a]) apply[a] = 1'b1;
         end
         FN_CLEAR_ALL: apply = r & ~w;
         FN_READ, FN_TEST, FN_TEST_ERROR: apply = r;
      endcase
   endfunction

   //----------------------------------------------------------------
   // channel acceptance
   //----------------------------------------------------------------
   // a second output while full is held off until the input clears it
   assign pri_accept = pri_out_valid & ~pri_full;
   assign sec_accept = SECOND_PRESENT & sec_out_valid & ~sec_full;
   assign pri_answer = answer(regs, pri_out_data, {NUM_BITS{1'b1}});
   assign sec_answer = answer(regs, sec_out_data, SECOND_MASK);

   //----------------------------------------------------------------
   // register next state
   //----------------------------------------------------------------
   // descriptor effects, then deadstart, then external status wins
   always_comb begin
      logic [NUM_BITS-1:0] upd;
      upd       = status_valid & IMPL_MASK & ~locked(regs);
      next_regs = regs;
      if (pri_accept) next_regs = apply(next_regs, pri_out_data, {NUM_BITS{1'b1}});
      if (sec_accept) next_regs = apply(next_regs, sec_out_data, SECOND_MASK);
      if (deadstart) next_regs = next_regs & ~DEADSTART_MASK;
      next_regs = (next_regs & ~upd) | (status_value & upd);
   end

   // register bits and their control outputs
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         regs                        <= REGS_RESET;
         control_bits                <= REGS_RESET;
         central_busy_clear          <= 1'b0;
         memory_data_returned_signal <= 1'b0;
      end else begin
         regs                        <= next_regs;
         control_bits                <= next_regs;
         central_busy_clear          <= next_regs[BIT_BUSY_CLEAR];
         memory_data_returned_signal <= next_regs[BIT_DATA_RETURN];
      end
   end

   //----------------------------------------------------------------
   // primary channel
   //----------------------------------------------------------------
   // full flag and status word for the primary channel
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         pri_full    <= 1'b0;
         pri_in_data <= STATUS_RESET;
         chan_active <= 1'b0;
      end else begin
         chan_active <= 1'b1;
         if (pri_accept) begin
            pri_full    <= 1'b1;
            pri_in_data <= pri_answer;
         end else if (pri_in_take && pri_full) begin
            pri_full <= 1'b0;
         end
      end
   end

   //----------------------------------------------------------------
   // second channel
   //----------------------------------------------------------------
   // full flag and status word for the second channel
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         sec_full    <= 1'b0;
         sec_in_data <= STATUS_RESET;
      end else if (sec_accept) begin
         sec_full    <= 1'b1;
         sec_in_data <= sec_answer;
      end else if (sec_in_take && sec_full) begin
         sec_full <= 1'b0;
      end
   end

   //----------------------------------------------------------------
   // checks
   //----------------------------------------------------------------
   // bits the primary channel may change, as a plain vector for indexing
   logic [NUM_BITS-1:0] pri_writable;
   assign pri_writable = writable(regs, {NUM_BITS{1'b1}});

   // channel reports active once out of reset
   a_chan_active: assert property (@(posedge core_clk) disable iff (!reset_n)
      reset_n |=> chan_active)
      else $error("channel not active");

   // primary channel handshake
   a_accept_sets_full: assert property (@(posedge core_clk) disable iff (!reset_n)
      pri_out_valid && !pri_full |=> pri_full)
      else $error("output did not set full");

   a_full_blocks_out: assert property (@(posedge core_clk) disable iff (!reset_n)
      pri_full && pri_out_valid && !pri_in_take |=> pri_full && $stable(pri_in_data))
      else $error("output accepted while full");

   a_take_frees: assert property (@(posedge core_clk) disable iff (!reset_n)
      pri_full && pri_in_take |=> !pri_full)
      else $error("input did not clear full");

   // second channel handshake
   a_sec_sets_full: assert property (@(posedge core_clk) disable iff (!reset_n)
      sec_accept |=> sec_full)
      else $error("second output did not set full");

   a_sec_refused: assert property (@(posedge core_clk) disable iff (!reset_n)
      sec_full && sec_out_valid && !sec_in_take |=> sec_full && $stable(sec_in_data))
      else $error("second output accepted while full");

   // answers carried to the status word
   a_test_error_or: assert property (@(posedge core_clk) disable iff (!reset_n)
      pri_accept && pri_out_data[FUNC_MSB:FUNC_LSB] == FN_TEST_ERROR
      |=> pri_in_data == {11'h000, |($past(regs[SUMMARY_LAST:0]) & IMPL_MASK[SUMMARY_LAST:0])})
      else $error("error summary answer wrong");

   a_test_upper_zero: assert property (@(posedge core_clk) disable iff (!reset_n)
      pri_accept && pri_out_data[FUNC_MSB:FUNC_LSB] == FN_TEST
      |=> pri_in_data[WORD_W-1:1] == 11'h000)
      else $error("test answer has upper bits");

   a_read_word_zero: assert property (@(posedge core_clk) disable iff (!reset_n)
      pri_accept && pri_out_data[FUNC_MSB:FUNC_LSB] == FN_READ
      && pri_out_data[ADDR_MSB:ADDR_LSB] == 8'h00
      |=> pri_in_data == ($past(regs[WORD_W-1:0]) & IMPL_MASK[WORD_W-1:0]))
      else $error("word read wrong");

   // register effects of descriptors and external inputs
   a_set_bit_sticks: assert property (@(posedge core_clk) disable iff (!reset_n)
      pri_accept && !sec_accept && !deadstart
      && pri_out_data[FUNC_MSB:FUNC_LSB] == FN_SET
      && pri_writable[pri_out_data[ADDR_MSB:ADDR_LSB]]
      && !status_valid[pri_out_data[ADDR_MSB:ADDR_LSB]]
      |=> regs[$past(pri_out_data[ADDR_MSB:ADDR_LSB])])
      else $error("set function lost");

   a_clear_bit_sticks: assert property (@(posedge core_clk) disable iff (!reset_n)
      pri_accept && !sec_accept
      && pri_out_data[FUNC_MSB:FUNC_LSB] == FN_CLEAR
      && pri_writable[pri_out_data[ADDR_MSB:ADDR_LSB]]
      && !status_valid[pri_out_data[ADDR_MSB:ADDR_LSB]]
      |=> !regs[$past(pri_out_data[ADDR_MSB:ADDR_LSB])])
      else $error("clear function lost");

   a_ext_override: assert property (@(posedge core_clk) disable iff (!reset_n)
      status_valid[0] |=> regs[0] == $past(status_value[0]))
      else $error("external status did not win");

   a_lock_holds: assert property (@(posedge core_clk) disable iff (!reset_n)
      regs[LOCK_FLAG_BIT] |=> regs[LOCK_LAST:LOCK_FIRST] == $past(regs[LOCK_LAST:LOCK_FIRST]))
      else $error("locked group changed");

   a_clear_all_keeps: assert property (@(posedge core_clk) disable iff (!reset_n)
      pri_accept && !sec_accept && !deadstart
      && pri_out_data[FUNC_MSB:FUNC_LSB] == FN_CLEAR_ALL
      && !(|(status_valid & READ_ONLY_MASK))
      |=> (regs & READ_ONLY_MASK) == ($past(regs) & READ_ONLY_MASK))
      else $error("clear all touched a read-only bit");

   a_unimpl_zero: assert property (@(posedge core_clk) disable iff (!reset_n)
      !(|(regs & ~IMPL_MASK)))
      else $error("unimplemented bit set");

   // control outputs and deadstart
   a_busy_release: assert property (@(posedge core_clk) disable iff (!reset_n)
      pri_accept && !sec_accept && !deadstart && !status_valid[BIT_BUSY_CLEAR]
      && pri_out_data[FUNC_MSB:FUNC_LSB] == FN_SET
      && pri_out_data[ADDR_MSB:ADDR_LSB] == 8'(BIT_BUSY_CLEAR)
      |=> central_busy_clear)
      else $error("busy release not raised");

   a_data_return: assert property (@(posedge core_clk) disable iff (!reset_n)
      sec_accept && !pri_accept && !deadstart && !status_valid[BIT_DATA_RETURN]
      && SECOND_MASK[BIT_DATA_RETURN]
      && sec_out_data[FUNC_MSB:FUNC_LSB] == FN_SET
      && sec_out_data[ADDR_MSB:ADDR_LSB] == 8'(BIT_DATA_RETURN)
      |=> memory_data_returned_signal)
      else $error("data returned signal not raised");

   a_deadstart_clears: assert property (@(posedge core_clk) disable iff (!reset_n)
      deadstart && DEADSTART_MASK[BIT_BUSY_CLEAR] && DEADSTART_MASK[BIT_DATA_RETURN]
      && !status_valid[BIT_BUSY_CLEAR] && !status_valid[BIT_DATA_RETURN]
      |=> !central_busy_clear && !memory_data_returned_signal)
      else $error("deadstart left a release bit set");
endmodule
`default_nettype wire

// file: design/scr_pkg.sv
// constants and types shared by the status and control register port
package scr_pkg;
   //--------------------------------------------------------------
   // geometry of the register and the descriptor
   //--------------------------------------------------------------
   localparam int WORD_W    = 12;
   localparam int NUM_WORDS = 16;
   localparam int NUM_BITS  = 192;
   localparam int ADDR_LSB  = 0;
   localparam int ADDR_MSB  = 7;
   localparam int UNUSED_BIT = 8;
   localparam int FUNC_LSB  = 9;
   localparam int FUNC_MSB  = 11;

   //--------------------------------------------------------------
   // channel numbers and notable bit positions
   //--------------------------------------------------------------
   localparam int CHAN_PRIMARY     = 'o16;
   localparam int CHAN_SECOND      = 'o36;
   localparam int PP_COUNT_SECOND  = 20;
   localparam int SUMMARY_LAST     = 39;
   localparam int BIT_BUSY_CLEAR   = 78;
   localparam int BIT_DATA_RETURN  = 79;
   localparam int LOCK_FLAG_BIT    = 3;
   localparam int LOCK_FIRST       = 40;
   localparam int LOCK_LAST        = 53;

   //--------------------------------------------------------------
   // reset values and default category masks
   //--------------------------------------------------------------
   localparam logic [NUM_BITS-1:0] REGS_RESET   = 192'h0;
   localparam logic [WORD_W-1:0]   STATUS_RESET = 12'h000;
   localparam logic [NUM_BITS-1:0] ONE_BIT      = 192'h1;
   localparam logic [NUM_BITS-1:0] LOCK_GROUP   =
      (ONE_BIT << (LOCK_LAST + 1)) - (ONE_BIT << LOCK_FIRST);
   localparam logic [NUM_BITS-1:0] DEF_READ_ONLY = (ONE_BIT << 76) - (ONE_BIT << 40);
   localparam logic [NUM_BITS-1:0] DEF_DEADSTART = ~((ONE_BIT << 76) - ONE_BIT);
   localparam logic [NUM_BITS-1:0] DEF_IMPL     =
      ~((ONE_BIT << 4) | (ONE_BIT << 38) | (ONE_BIT << 39));
   localparam logic [NUM_BITS-1:0] DEF_SECOND   =
      ((ONE_BIT << 40) - ONE_BIT) | ((ONE_BIT << 80) - (ONE_BIT << 60));

   // descriptor function codes
   typedef enum logic [2:0] {
      FN_READ       = 3'b000,
      FN_TEST       = 3'b001,
      FN_CLEAR      = 3'b010,
      FN_TEST_CLEAR = 3'b011,
      FN_SET        = 3'b100,
      FN_TEST_SET   = 3'b101,
      FN_CLEAR_ALL  = 3'b110,
      FN_TEST_ERROR = 3'b111
   } func_t;
endpackage

// file: test/pp_model.sv
// peripheral processor model issuing one descriptor then one status input
`timescale 1ns/1ps
`default_nettype none
module pp_model
   import scr_pkg::*;
(
   input  wire logic              core_clk,
   output var  logic              out_valid,
   output var  logic [WORD_W-1:0] out_data,
   output var  logic              in_take,
   input  wire logic [WORD_W-1:0] in_data,
   input  wire logic              full
);
   //--------------------------------------------------------------
   // channel transfer
   //--------------------------------------------------------------
   // idle levels at time zero, data line never left at a stale value
   initial begin
      out_valid = 1'b0;
      out_data  = 12'h0a5;
      in_take   = 1'b0;
   end

   // one output, wait for full, one input held for one cycle, no wait for empty
   task automatic xfer(input logic [2:0] fn, input logic [7:0] addr,
                       output logic [WORD_W-1:0] resp);
      logic [WORD_W-1:0] d;
      int                n;
      d    = {fn, 1'b0, addr};
      resp = 'x;
      @(posedge core_clk);
      out_valid <= 1'b1;
      out_data  <= d;
      n = 0;
      do begin
         @(negedge core_clk);
         n++;
      end while (full !== 1'b1 && n < 20);
      @(posedge core_clk);
      resp = in_data;
      out_valid <= 1'b0;
      out_data  <= ~d; // released line shows no stale value
      in_take   <= 1'b1;
      @(posedge core_clk);
      in_take   <= 1'b0;
   endtask
endmodule
`default_nettype wire

// file: test/status_control_register_port_tb.sv
// self-checking bench for the status and control register port
`timescale 1ns/1ps
`default_nettype none
module status_control_register_port_tb;
   import scr_pkg::*;
   //--------------------------------------------------------------
   // clock, reset and design hookup
   //--------------------------------------------------------------
   logic                core_clk = 1'b0;
   logic                reset_n = 1'b0;
   logic                deadstart = 1'b0;
   logic [NUM_BITS-1:0] status_valid = '0;
   logic [NUM_BITS-1:0] status_value = '0;
   logic [NUM_BITS-1:0] control_bits;
   logic                pri_ov, pri_take, pri_full, sec_ov, sec_take, sec_full;
   logic [WORD_W-1:0]   pri_od, pri_id, sec_od, sec_id;
   logic                chan_active, central_busy_clear, memory_data_returned_signal;
   int                  failures = 0;
   int                  checks_done = 0;
   int                  cycles = 0;

   always #4 core_clk = ~core_clk;

   status_control_register_port i_dut (
      .core_clk(core_clk), .reset_n(reset_n), .deadstart(deadstart),
      .status_valid(status_valid), .status_value(status_value),
      .pri_out_valid(pri_ov), .pri_out_data(pri_od), .pri_in_take(pri_take),
      .pri_in_data(pri_id), .pri_full(pri_full),
      .sec_out_valid(sec_ov), .sec_out_data(sec_od), .sec_in_take(sec_take),
      .sec_in_data(sec_id), .sec_full(sec_full),
      .chan_active(chan_active), .control_bits(control_bits),
      .central_busy_clear(central_busy_clear),
      .memory_data_returned_signal(memory_data_returned_signal));

   pp_model i_pri (.core_clk(core_clk), .out_valid(pri_ov), .out_data(pri_od),
      .in_take(pri_take), .in_data(pri_id), .full(pri_full));
   pp_model i_sec (.core_clk(core_clk), .out_valid(sec_ov), .out_data(sec_od),
      .in_take(sec_take), .in_data(sec_id), .full(sec_full));

   //--------------------------------------------------------------
   // compare, drive and report helpers
   //--------------------------------------------------------------
   task automatic check_word(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
      end
   endtask

   task automatic check_bit(input logic got, input logic exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
      end
   endtask

   // one descriptor on channel 16 or 36, status word compared
   task automatic op(input bit s, input func_t fn, input int a, input logic [11:0] exp);
      logic [WORD_W-1:0] r;
      if (s) i_sec.xfer(fn, a[7:0], r);
      else i_pri.xfer(fn, a[7:0], r);
      check_word(r, exp);
   endtask

   // one-cycle external status load
   task automatic ext(input int i, input logic v);
      @(posedge core_clk);
      status_valid[i] <= 1'b1;
      status_value[i] <= v;
      @(posedge core_clk);
      status_valid[i] <= 1'b0;
   endtask

   task automatic finish_test();
      $display("checks_done %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   //--------------------------------------------------------------
   // scenarios
   //--------------------------------------------------------------
   task automatic t_ctrl();
      @(negedge core_clk);
      check_bit(chan_active, 1'b1);
      op(0, FN_SET, 78, 12'h000);
      check_bit(central_busy_clear, 1'b1);
      op(1, FN_SET, 79, 12'h000);
      check_bit(memory_data_returned_signal, 1'b1);
      op(0, FN_READ, 6, 12'h0c0);
      op(0, FN_CLEAR, 78, 12'h000);
      check_bit(central_busy_clear, 1'b0);
   endtask

   task automatic t_test();
      op(0, FN_TEST_SET, 5, 12'h000);
      op(0, FN_TEST, 5, 12'h001);
      op(0, FN_READ, 0, 12'h020);
      op(0, FN_TEST_CLEAR, 5, 12'h001);
      op(0, FN_TEST, 5, 12'h000);
      op(0, FN_TEST_ERROR, 0, 12'h000);
      op(1, FN_SET, 10, 12'h000);
      op(0, FN_TEST_ERROR, 0, 12'h001);
      op(0, FN_CLEAR_ALL, 0, 12'h000);
      op(0, FN_TEST_ERROR, 0, 12'h000);
      check_bit(memory_data_returned_signal, 1'b0);
   endtask

   task automatic t_lock();
      ext(45, 1'b1);
      ext(3, 1'b1);
      ext(45, 1'b0);
      op(0, FN_READ, 3, 12'h200);
      op(0, FN_TEST, 45, 12'h000);
      op(0, FN_CLEAR, 45, 12'h000);
      op(0, FN_CLEAR_ALL, 0, 12'h000);
      op(0, FN_READ, 3, 12'h200);
      ext(45, 1'b0);
      op(0, FN_READ, 3, 12'h000);
   endtask

   task automatic t_misc();
      ext(0, 1'b1);
      op(0, FN_TEST, 0, 12'h001);
      op(0, FN_CLEAR, 0, 12'h000);
      @(posedge core_clk);
      status_valid[20] <= 1'b1;
      status_value[20] <= 1'b0;
      op(0, FN_SET, 20, 12'h000);
      op(0, FN_TEST, 20, 12'h000);
      status_valid[20] <= 1'b0;
      op(1, FN_SET, 100, 12'h000);
      op(0, FN_TEST, 100, 12'h000);
      op(0, FN_SET, 100, 12'h000);
      op(0, FN_TEST, 100, 12'h001);
      check_bit(control_bits[100], 1'b1);
      op(0, FN_SET, 78, 12'h000);
      @(posedge core_clk);
      deadstart <= 1'b1;
      @(posedge core_clk);
      deadstart <= 1'b0;
      op(0, FN_TEST, 100, 12'h000);
      check_bit(central_busy_clear, 1'b0);
      op(0, FN_SET, 4, 12'h000);
      op(0, FN_TEST, 4, 12'h000);
   endtask

   //--------------------------------------------------------------
   // timeout and main sequence
   //--------------------------------------------------------------
   // cut a hang short well past the expected run length
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 5000) begin
         failures++;
         $display("unexpected at %0t: run timed out", $time);
         finish_test();
      end
   end

   initial begin
      repeat (4) @(posedge core_clk);
      reset_n <= 1'b1;
      @(posedge core_clk);
      t_ctrl();
      t_test();
      t_lock();
      t_misc();
      finish_test();
   end
endmodule
`default_nettype wire
